// file: hdl/scma_dev.sv
// Overview of operation
// - EEPROM write stores two bytes, 12 ms
// - Leave command ends command mode, normal operation
// - Enter accepted only in power-on window, 10 ms
// - Revision query executes in 100 us
// - Host sends enter within 10 ms
// - Write frame 0x50, read frame 0x51
// - Enter success fetches response 0x81
// - Host reads address word with 0x1C
// - Factory answer is 0x81 0x00 0x28
// - Command 0x5C stores new address
// - Verify read returns newly written address
// - Failed read restarts from power-on
// - Any failure removes device power
// - Write payload in data, reads send zeros
// - Address sits in low byte bits 6:0
// - Command 0x80 ends mode, zero data
`timescale 1ns/1ps
module scma_dev #(
  parameter int CM_WIN_CYC = scma_pkg::CM_WIN_CYC,
  parameter int RESP_CYC = scma_pkg::RESP_CYC,
  parameter int EE_WR_CYC = scma_pkg::EE_WR_CYC,
  parameter logic [15:0] REV_CODE = 16'h0001 // Arbitrary value
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Link
  scma_link_if.dev link,
  // User side status
  output logic cmd_mode,
  output logic norm_mode,
  output logic [6:0] active_addr
);
  typedef enum logic [3:0] {
    ST_PRE = 4'b0001,
    ST_CMD = 4'b0010,
    ST_BUSY = 4'b0100,
    ST_NORM = 4'b1000
  } scma_dst_t;

  scma_dst_t state_r;
  logic started_r;
  logic sel_wr_r;
  logic sel_rd_r;
  logic [1:0] idx_r;
  logic [7:0] cmd_r;
  logic [7:0] hi_r;
  logic [7:0] lo_r;
  logic [15:0] rsp_r;
  logic [1:0] resp_code_r;
  logic [6:0] act_addr_r;
  logic [7:0] rd_data_r;
  logic rd_vld_r;
  logic [15:0] ee_mem_r [scma_pkg::EE_DEPTH];
  logic win_open;
  logic rsp_load;
  logic [scma_pkg::TMR_W-1:0] rsp_val;
  logic rsp_done;
  logic exec;
  logic [1:0] cmd_cls;
  logic [5:0] ee_idx;
  logic [7:0] stat_byte;
  logic addr_hit;

  // ------------------------------------------------------------
  // Power-on command window
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
    started_r <= !sys_rst;
  scma_timer #(.W(scma_pkg::TMR_W)) u_win (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(!started_r),
    .load_val(scma_pkg::TMR_W'(CM_WIN_CYC)),
    .running(win_open),
    .done()
  );
  scma_timer #(.W(scma_pkg::TMR_W)) u_rsp (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(rsp_load),
    .load_val(rsp_val),
    .running(),
    .done(rsp_done)
  );

  // ------------------------------------------------------------
  // Frame parsing
  // ------------------------------------------------------------
  assign addr_hit = (link.tok_data[7:1] == act_addr_r);
  assign exec = link.tok_vld && (link.tok_kind == scma_pkg::TOK_STOP) && sel_wr_r && (idx_r == 2'h3);
  assign cmd_cls = cmd_r[7:6];
  assign ee_idx = cmd_r[5:0];

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sel_wr_r <= 1'b0;
      sel_rd_r <= 1'b0;
      idx_r <= 2'h0;
    end
    else if (link.tok_vld && link.tok_kind == scma_pkg::TOK_START)
    begin
      sel_wr_r <= addr_hit && !link.tok_data[scma_pkg::RW_BIT];
      sel_rd_r <= addr_hit && link.tok_data[scma_pkg::RW_BIT];
      idx_r <= 2'h0;
    end
    else if (link.tok_vld && link.tok_kind == scma_pkg::TOK_STOP)
    begin
      sel_wr_r <= 1'b0;
      sel_rd_r <= 1'b0;
    end
    else if ((link.tok_vld && link.tok_kind == scma_pkg::TOK_DATA && sel_wr_r) || (link.rd_req && sel_rd_r))
    begin
      if (idx_r != 2'h3)
        idx_r <= idx_r + 2'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cmd_r <= 8'h00;
      hi_r <= 8'h00;
      lo_r <= 8'h00;
    end
    else if (link.tok_vld && link.tok_kind == scma_pkg::TOK_DATA && sel_wr_r)
    begin
      if (idx_r == 2'h0)
        cmd_r <= link.tok_data;
      else if (idx_r == 2'h1)
        hi_r <= link.tok_data;
      else if (idx_r == 2'h2)
        lo_r <= link.tok_data;
    end
  end

  // ------------------------------------------------------------
  // Command execution
  // ------------------------------------------------------------
  always_comb
  begin
    rsp_load = 1'b0;
    rsp_val = scma_pkg::TMR_W'(RESP_CYC);
    if (exec && state_r == ST_PRE && cmd_r == scma_pkg::CMD_ENTER && win_open)
      rsp_load = 1'b1;
    else if (exec && state_r == ST_CMD && cmd_r != scma_pkg::CMD_LEAVE)
    begin
      rsp_load = (cmd_r == scma_pkg::CMD_ENTER) || (cmd_r == scma_pkg::CMD_REV) ||
                 (cmd_cls == scma_pkg::CMD_CLS_RD) || (cmd_cls == scma_pkg::CMD_CLS_WR);
      if (cmd_cls == scma_pkg::CMD_CLS_WR)
        rsp_val = scma_pkg::TMR_W'(EE_WR_CYC);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      state_r <= ST_PRE;
    else
    begin
      case (state_r)
        ST_PRE:
        begin
          if (rsp_load)
            state_r <= ST_BUSY;
          else if (!win_open && started_r)
            state_r <= ST_NORM;
        end
        ST_CMD:
        begin
          if (exec && cmd_r == scma_pkg::CMD_LEAVE)
            state_r <= ST_NORM;
          else if (rsp_load)
            state_r <= ST_BUSY;
        end
        ST_BUSY:
        begin
          if (rsp_done)
            state_r <= ST_CMD;
        end
        default:
          state_r <= ST_NORM;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rsp_r <= 16'h0000;
      resp_code_r <= scma_pkg::RESP_ACK;
    end
    else if (exec && state_r == ST_CMD)
    begin
      resp_code_r <= rsp_load ? scma_pkg::RESP_ACK : scma_pkg::RESP_NACK;
      if (cmd_r == scma_pkg::CMD_REV)
        rsp_r <= REV_CODE;
      else if (cmd_cls == scma_pkg::CMD_CLS_RD)
        rsp_r <= ee_mem_r[ee_idx];
      else if (cmd_cls == scma_pkg::CMD_CLS_WR)
        rsp_r <= {hi_r, lo_r};
    end
  end

  // ------------------------------------------------------------
  // EEPROM words and active address
  // ------------------------------------------------------------
  generate
    for (genvar i = 0; i < scma_pkg::EE_DEPTH; i++)
    begin : g_ee
      always_ff @(posedge core_clk)
      begin
        if (sys_rst)
          ee_mem_r[i] <= (6'(i) == scma_pkg::EE_ADDR_WORD) ? scma_pkg::EE_ADDR_RST : scma_pkg::EE_RST_VAL;
        else if (exec && state_r == ST_CMD && cmd_cls == scma_pkg::CMD_CLS_WR && ee_idx == 6'(i))
          ee_mem_r[i] <= {hi_r, lo_r};
      end
    end
  endgenerate
  // Old address stays valid while in command mode
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      act_addr_r <= scma_pkg::DEV_ADDR_DFLT;
    else if (exec && state_r == ST_CMD && cmd_r == scma_pkg::CMD_LEAVE)
      act_addr_r <= ee_mem_r[scma_pkg::EE_ADDR_WORD][6:0];
  end

  // ------------------------------------------------------------
  // Data fetch
  // ------------------------------------------------------------
  assign stat_byte = (state_r == ST_BUSY) ? {scma_pkg::STAT_CMD, scma_pkg::DIAG_OK, scma_pkg::RESP_BUSY} :
                     (state_r == ST_CMD) ? {scma_pkg::STAT_CMD, scma_pkg::DIAG_OK, resp_code_r} :
                     {scma_pkg::STAT_NORM, scma_pkg::DIAG_OK, scma_pkg::RESP_BUSY};
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rd_data_r <= 8'h00;
      rd_vld_r <= 1'b0;
    end
    else
    begin
      rd_vld_r <= link.rd_req && sel_rd_r;
      if (link.rd_req && sel_rd_r)
      begin
        if (idx_r == 2'h0)
          rd_data_r <= stat_byte;
        else if (idx_r == 2'h1 && state_r == ST_CMD)
          rd_data_r <= rsp_r[15:8];
        else if (idx_r == 2'h2 && state_r == ST_CMD)
          rd_data_r <= rsp_r[7:0];
        else
          rd_data_r <= 8'h00;
      end
    end
  end

  assign link.rd_data = rd_data_r;
  assign link.rd_vld = rd_vld_r;
  assign link.addr_ack = sel_wr_r || sel_rd_r;
  assign cmd_mode = (state_r == ST_CMD) || (state_r == ST_BUSY);
  assign norm_mode = (state_r == ST_NORM);
  assign active_addr = act_addr_r;
endmodule

// file: pkg/scma_pkg.sv
package scma_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int CM_WIN_MS = 10;
  localparam int RESP_US = 100;
  localparam int EE_WR_MS = 12;
  localparam int CM_WIN_CYC = CM_WIN_MS * (CLK_HZ / 1000);
  localparam int RESP_CYC = RESP_US * (CLK_HZ / 1_000_000);
  localparam int EE_WR_CYC = EE_WR_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 24;

  // ------------------------------------------------------------
  // Link tokens
  // ------------------------------------------------------------
  localparam logic [1:0] TOK_START = 2'h1;
  localparam logic [1:0] TOK_DATA = 2'h2;
  localparam logic [1:0] TOK_STOP = 2'h3;
  localparam int RW_BIT = 0;

  // ------------------------------------------------------------
  // Addresses and commands
  // ------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h28;
  localparam logic [7:0] WR_FRAME_BYTE = 8'h50;
  localparam logic [7:0] RD_FRAME_BYTE = 8'h51;
  localparam logic [7:0] CMD_ENTER = 8'hA0;
  localparam logic [7:0] CMD_LEAVE = 8'h80;
  localparam logic [7:0] CMD_REV = 8'hB0;
  localparam logic [7:0] CMD_ADDR_RD = 8'h1C;
  localparam logic [7:0] CMD_ADDR_WR = 8'h5C;
  localparam logic [1:0] CMD_CLS_RD = 2'h0;
  localparam logic [1:0] CMD_CLS_WR = 2'h1;
  localparam int EE_IDX_W = 6;
  localparam int EE_DEPTH = 64;
  localparam logic [5:0] EE_ADDR_WORD = 6'h1C;
  localparam logic [15:0] EE_RST_VAL = 16'h0000;
  localparam logic [15:0] EE_ADDR_RST = 16'h0028;

  // ------------------------------------------------------------
  // Response byte fields
  // ------------------------------------------------------------
  localparam logic [1:0] STAT_CMD = 2'h2;
  localparam logic [1:0] STAT_NORM = 2'h0;
  localparam logic [3:0] DIAG_OK = 4'h0;
  localparam logic [1:0] RESP_BUSY = 2'h0;
  localparam logic [1:0] RESP_ACK = 2'h1;
  localparam logic [1:0] RESP_NACK = 2'h2;
  localparam logic [7:0] ACK_BYTE = 8'h81;

endpackage

// file: pkg/scma_link_if.sv
`timescale 1ns/1ps
interface scma_link_if;
  logic tok_vld;
  logic [1:0] tok_kind;
  logic [7:0] tok_data;
  logic rd_req;
  logic [7:0] rd_data;
  logic rd_vld;
  logic addr_ack;

  modport dev (
    input tok_vld,
    input tok_kind,
    input tok_data,
    input rd_req,
    output rd_data,
    output rd_vld,
    output addr_ack
  );

  modport host (
    output tok_vld,
    output tok_kind,
    output tok_data,
    output rd_req,
    input rd_data,
    input rd_vld,
    input addr_ack
  );
endinterface

// file: hdl/scma_timer.sv
`timescale 1ns/1ps
module scma_timer #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Status
  output logic running,
  output logic done
);
  logic [W-1:0] count_r;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      count_r <= '0;
    else if (load)
      count_r <= load_val;
    else if (count_r != '0)
      count_r <= count_r - W'(1);
  end

  assign running = (count_r != '0);
  assign done = (count_r == W'(1));
endmodule

// file: hdl/scma_host.sv
`timescale 1ns/1ps
module scma_host #(
  parameter int RESP_CYC = scma_pkg::RESP_CYC,
  parameter int EE_WR_CYC = scma_pkg::EE_WR_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // User request
  input wire logic go,
  input wire logic [6:0] new_addr,
  // User status
  output logic busy,
  output logic done,
  output logic ok,
  output logic pwr_off,
  // Link
  scma_link_if.host link
);
  typedef enum logic [6:0] {
    H_IDLE = 7'b0000001,
    H_WR = 7'b0000010,
    H_WAIT = 7'b0000100,
    H_RD = 7'b0001000,
    H_RQ = 7'b0010000,
    H_RV = 7'b0100000,
    H_END = 7'b1000000
  } scma_hst_t;

  scma_hst_t state_r;
  logic [2:0] step_r;
  logic [2:0] tix_r;
  logic [1:0] bix_r;
  logic fail_r;
  logic tok_vld_r;
  logic [1:0] tok_kind_r;
  logic [7:0] tok_data_r;
  logic rd_req_r;
  logic [7:0] cmd_b;
  logic [7:0] lo_b;
  logic [7:0] exp_b;
  logic [1:0] nbytes;
  logic tmr_load;
  logic tmr_done;

  // ------------------------------------------------------------
  // Step table
  // ------------------------------------------------------------
  always_comb
  begin
    cmd_b = scma_pkg::CMD_ENTER;
    lo_b = 8'h00;
    nbytes = 2'h1;
    if (step_r == 3'h1 || step_r == 3'h3)
    begin
      cmd_b = scma_pkg::CMD_ADDR_RD;
      nbytes = 2'h3;
    end
    else if (step_r == 3'h2)
    begin
      cmd_b = scma_pkg::CMD_ADDR_WR;
      lo_b = {1'b0, new_addr};
    end
    else if (step_r == 3'h4)
      cmd_b = scma_pkg::CMD_LEAVE;
    exp_b = scma_pkg::ACK_BYTE;
    if (bix_r == 2'h1)
      exp_b = 8'h00;
    else if (bix_r == 2'h2)
      exp_b = (step_r == 3'h1) ? {1'b0, scma_pkg::DEV_ADDR_DFLT} : {1'b0, new_addr};
  end

  assign tmr_load = (state_r == H_WR) && (tix_r == 3'h4);

  scma_timer #(.W(scma_pkg::TMR_W)) u_wait (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .load_val(scma_pkg::TMR_W'((step_r == 3'h2) ? EE_WR_CYC : RESP_CYC)),
    .running(),
    .done(tmr_done)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_r <= H_IDLE;
      step_r <= 3'h0;
      tix_r <= 3'h0;
      bix_r <= 2'h0;
      fail_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        H_IDLE:
        begin
          if (go)
          begin
            state_r <= H_WR;
            step_r <= 3'h0;
            tix_r <= 3'h0;
            fail_r <= 1'b0;
          end
        end
        H_WR:
        begin
          tix_r <= tix_r + 3'h1;
          if (tix_r == 3'h2 && !link.addr_ack)
            fail_r <= 1'b1;
          if (tix_r == 3'h4)
            state_r <= H_WAIT;
        end
        H_WAIT:
        begin
          if (tmr_done)
            state_r <= (step_r == 3'h4) ? H_END : H_RD;
          bix_r <= 2'h0;
        end
        H_RD:
          state_r <= H_RQ;
        H_RQ:
          state_r <= H_RV;
        H_RV:
        begin
          if (!link.addr_ack)
          begin
            fail_r <= 1'b1;
            state_r <= H_END;
          end
          else if (link.rd_vld)
          begin
            bix_r <= bix_r + 2'h1;
            if (link.rd_data != exp_b)
            begin
              fail_r <= 1'b1;
              state_r <= H_END;
            end
            else if (bix_r + 2'h1 != nbytes)
              state_r <= H_RQ;
            else
            begin
              state_r <= H_WR;
              step_r <= step_r + 3'h1;
              tix_r <= 3'h0;
            end
          end
        end
        default:
        begin
          if (go)
          begin
            state_r <= H_WR;
            step_r <= 3'h0;
            tix_r <= 3'h0;
            fail_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Link drive
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tok_vld_r <= 1'b0;
      tok_kind_r <= scma_pkg::TOK_STOP;
      tok_data_r <= 8'h00;
      rd_req_r <= 1'b0;
    end
    else
    begin
      tok_vld_r <= (state_r == H_WR) || (state_r == H_RD) ||
                   (state_r == H_RV && link.rd_vld && (bix_r + 2'h1 == nbytes || link.rd_data != exp_b)) ||
                   (state_r == H_RV && !link.addr_ack);
      rd_req_r <= (state_r == H_RQ);
      if (state_r == H_WR)
      begin
        tok_kind_r <= (tix_r == 3'h0) ? scma_pkg::TOK_START : (tix_r == 3'h4) ? scma_pkg::TOK_STOP : scma_pkg::TOK_DATA;
        if (tix_r == 3'h0)
          tok_data_r <= scma_pkg::WR_FRAME_BYTE;
        else if (tix_r == 3'h1)
          tok_data_r <= cmd_b;
        else if (tix_r == 3'h3)
          tok_data_r <= lo_b;
        else
          tok_data_r <= 8'h00;
      end
      else if (state_r == H_RD)
      begin
        tok_kind_r <= scma_pkg::TOK_START;
        tok_data_r <= scma_pkg::RD_FRAME_BYTE;
      end
      else
      begin
        tok_kind_r <= scma_pkg::TOK_STOP;
        tok_data_r <= 8'h00;
      end
    end
  end

  assign link.tok_vld = tok_vld_r;
  assign link.tok_kind = tok_kind_r;
  assign link.tok_data = tok_data_r;
  assign link.rd_req = rd_req_r;
  assign busy = (state_r != H_IDLE) && (state_r != H_END);
  assign done = (state_r == H_END);
  assign ok = (state_r == H_END) && !fail_r;
  assign pwr_off = (state_r == H_END) && fail_r;
endmodule

// file: verification/scma_link_assertions.sv
`timescale 1ns/1ps
module scma_checker #(
  parameter int CM_WIN_CYC = scma_pkg::CM_WIN_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Link
  input wire logic tok_vld,
  input wire logic [1:0] tok_kind,
  input wire logic [7:0] tok_data,
  input wire logic rd_req,
  input wire logic [7:0] rd_data,
  input wire logic rd_vld,
  input wire logic addr_ack
);
  localparam int FETCH_MAX = 64;
  localparam int WR_FETCH_MAX = 128;
  logic [scma_pkg::TMR_W-1:0] since_rst_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // Cycles since reset release, saturating
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      since_rst_r <= '0;
    else if (~since_rst_r != '0)
      since_rst_r <= since_rst_r + scma_pkg::TMR_W'(1);
  end

  // ----------------------------------------
  // Frame sequences
  // ----------------------------------------
  sequence s_tok(logic [1:0] k, logic [7:0] d);
    tok_vld && tok_kind == k && tok_data == d;
  endsequence

  sequence s_cmd(logic [7:0] c);
    s_tok(scma_pkg::TOK_START, scma_pkg::WR_FRAME_BYTE) ##1 s_tok(scma_pkg::TOK_DATA, c);
  endsequence

  sequence s_ack_byte;
    rd_vld && rd_data == scma_pkg::ACK_BYTE;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_start_gets_ack: assert property (
    tok_vld && tok_kind == scma_pkg::TOK_START && tok_data[7:1] == scma_pkg::DEV_ADDR_DFLT |=> addr_ack)
    else $error("addr_ack missing after matching start");
  a_ack_ends_stop: assert property (addr_ack && tok_vld && tok_kind == scma_pkg::TOK_STOP |=> !addr_ack)
    else $error("addr_ack held after stop");
  a_ack_has_cause: assert property ($rose(addr_ack) |-> $past(tok_vld) && $past(tok_kind) == scma_pkg::TOK_START)
    else $error("addr_ack rose without start");
  a_read_answer: assert property (rd_req && addr_ack |=> rd_vld)
    else $error("rd_vld missing after rd_req");
  a_vld_needs_req: assert property (rd_vld |-> $past(rd_req) && $past(addr_ack))
    else $error("rd_vld without selected rd_req");
  a_enter_in_window: assert property (s_cmd(scma_pkg::CMD_ENTER) |-> since_rst_r < CM_WIN_CYC)
    else $error("enter command sent after window");
  a_enter_reply: assert property (s_cmd(scma_pkg::CMD_ENTER) |-> ##[1:FETCH_MAX] s_ack_byte)
    else $error("enter not answered with ack byte");
  a_cfg_reply: assert property (
    s_cmd(scma_pkg::CMD_ADDR_RD) |-> ##[1:FETCH_MAX] s_ack_byte ##[1:8] (rd_vld && rd_data == 8'h00))
    else $error("config read answer wrong");
  a_addr_wr_reply: assert property (s_cmd(scma_pkg::CMD_ADDR_WR) |-> ##[1:WR_FETCH_MAX] s_ack_byte)
    else $error("address write not acknowledged");
  a_read_zero_data: assert property (
    s_cmd(scma_pkg::CMD_ADDR_RD) |=> s_tok(scma_pkg::TOK_DATA, 8'h00) ##1 s_tok(scma_pkg::TOK_DATA, 8'h00))
    else $error("read command data not zero");
  a_leave_zero_data: assert property (
    s_cmd(scma_pkg::CMD_LEAVE) |=> s_tok(scma_pkg::TOK_DATA, 8'h00) ##1 s_tok(scma_pkg::TOK_DATA, 8'h00))
    else $error("leave command data not zero");
endmodule

// file: verification/sensor_command_mode_address_change_bench.sv
`timescale 1ns/1ps
module sensor_command_mode_address_change_bench;
  localparam int WIN = 400;
  localparam int RSP = 20;
  localparam int EEW = 50;
  localparam logic [15:0] REV_B = 16'h5A3C; // Arbitrary value
  logic core_clk, sys_rst, rst_b, go;
  logic [6:0] new_addr, a_addr, b_addr;
  logic h_busy, h_done, h_ok, h_off, c_done, c_ok, c_off;
  logic a_cmd, a_norm, b_cmd, b_norm;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] dq[$], sq[$], rq[$], fb[3];
  logic [7:0] ed[15] = '{8'hA0, 8'h00, 8'h00, 8'h1C, 8'h00, 8'h00, 8'h5C, 8'h00, 8'h31,
    8'h1C, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
  logic [7:0] er[8] = '{8'h81, 8'h81, 8'h00, 8'h28, 8'h81, 8'h81, 8'h00, 8'h31};

  scma_link_if link_a();
  scma_link_if link_b();
  scma_link_if link_c();
  // Far end that never answers
  assign link_c.addr_ack = 1'b0;
  assign link_c.rd_vld = 1'b0;
  assign link_c.rd_data = 8'hA5;

  scma_dev #(.CM_WIN_CYC(WIN), .RESP_CYC(RSP), .EE_WR_CYC(EEW)) u_scma_dev (.core_clk(core_clk),
    .sys_rst(sys_rst), .link(link_a), .cmd_mode(a_cmd), .norm_mode(a_norm), .active_addr(a_addr));
  scma_host #(.RESP_CYC(RSP), .EE_WR_CYC(EEW)) u_scma_host (.core_clk(core_clk), .sys_rst(sys_rst),
    .go(go), .new_addr(new_addr), .busy(h_busy), .done(h_done), .ok(h_ok), .pwr_off(h_off), .link(link_a));
  scma_dev #(.CM_WIN_CYC(WIN), .RESP_CYC(RSP), .EE_WR_CYC(EEW), .REV_CODE(REV_B)) u_scma_dev_b (
    .core_clk(core_clk), .sys_rst(rst_b), .link(link_b), .cmd_mode(b_cmd), .norm_mode(b_norm),
    .active_addr(b_addr));
  scma_host #(.RESP_CYC(RSP), .EE_WR_CYC(EEW)) u_scma_host_c (.core_clk(core_clk), .sys_rst(sys_rst),
    .go(go), .new_addr(new_addr), .busy(), .done(c_done), .ok(c_ok), .pwr_off(c_off), .link(link_c));
  scma_checker #(.CM_WIN_CYC(WIN)) u_scma_checker (.core_clk(core_clk), .sys_rst(sys_rst),
    .tok_vld(link_a.tok_vld), .tok_kind(link_a.tok_kind), .tok_data(link_a.tok_data), .rd_req(link_a.rd_req),
    .rd_data(link_a.rd_data), .rd_vld(link_a.rd_vld), .addr_ack(link_a.addr_ack));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic complete_run;
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      complete_run;
    end
  end

  // Wire record of the device-to-host pair
  always @(posedge core_clk)
  begin
    if (!sys_rst && link_a.tok_vld && link_a.tok_kind == scma_pkg::TOK_DATA)
      dq.push_back(link_a.tok_data);
    if (!sys_rst && link_a.tok_vld && link_a.tok_kind == scma_pkg::TOK_START)
      sq.push_back(link_a.tok_data);
    if (!sys_rst && link_a.rd_vld)
      rq.push_back(link_a.rd_data);
  end

  // ----------------------------------------
  // Token link driver
  // ----------------------------------------
  task automatic tok_b(input logic [1:0] k, input logic [7:0] d);
    @(negedge core_clk);
    link_b.tok_vld = 1'b1;
    link_b.tok_kind = k;
    link_b.tok_data = d;
  endtask

  task automatic idle_b;
    @(negedge core_clk);
    link_b.tok_vld = 1'b0;
    link_b.rd_req = 1'b0;
  endtask

  task automatic wr_b(input logic [7:0] c, input logic [7:0] h, input logic [7:0] l);
    tok_b(scma_pkg::TOK_START, scma_pkg::WR_FRAME_BYTE);
    tok_b(scma_pkg::TOK_DATA, c);
    tok_b(scma_pkg::TOK_DATA, h);
    tok_b(scma_pkg::TOK_DATA, l);
    tok_b(scma_pkg::TOK_STOP, 8'h00);
    idle_b;
  endtask

  task automatic rd_b(input int n);
    tok_b(scma_pkg::TOK_START, scma_pkg::RD_FRAME_BYTE);
    idle_b;
    for (int i = 0; i < n; i++)
    begin
      @(negedge core_clk);
      link_b.rd_req = 1'b1;
      idle_b;
      chk_bit(link_b.rd_vld, 1'b1);
      fb[i] = link_b.rd_data;
    end
    tok_b(scma_pkg::TOK_STOP, 8'h00);
    idle_b;
  endtask

  task automatic cmd_b(input logic [7:0] c, input logic [7:0] h, input logic [7:0] l, input int wt,
    input int n, input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
    wr_b(c, h, l);
    repeat (wt) @(negedge core_clk);
    rd_b(n);
    chk_byte(fb[0], e0);
    if (n > 1)
    begin
      chk_byte(fb[1], e1);
      chk_byte(fb[2], e2);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic flow_a;
    int n;
    n = 0;
    @(negedge core_clk);
    go = 1'b1;
    @(negedge core_clk);
    go = 1'b0;
    chk_bit(h_busy, 1'b1);
    while (h_done !== 1'b1 && n < 2000)
    begin
      @(negedge core_clk);
      n++;
    end
    chk_bit(h_ok, 1'b1);
    chk_bit(h_off, 1'b0);
    chk_bit(a_norm && !a_cmd && !h_busy, 1'b1);
    chk_byte({1'b0, a_addr}, 8'h31);
    chk_bit(c_done && c_off && !c_ok, 1'b1);
    chk_byte(8'(dq.size()), 8'h0F);
    for (int i = 0; i < 15; i++)
      chk_byte(dq[i], ed[i]);
    for (int i = 0; i < 8; i++)
      chk_byte(rq[i], er[i]);
    chk_byte(8'(sq.size()), 8'h09);
    for (int i = 0; i < 9; i++)
      chk_byte(sq[i], (i % 2) ? scma_pkg::RD_FRAME_BYTE : scma_pkg::WR_FRAME_BYTE);
  endtask

  task automatic flow_b;
    cmd_b(scma_pkg::CMD_ENTER, 8'h00, 8'h00, RSP + 2, 1, scma_pkg::ACK_BYTE, 8'h00, 8'h00);
    chk_bit(b_cmd, 1'b1);
    wr_b(8'h45, 8'h12, 8'hC4);
    rd_b(1);
    chk_byte(fb[0], 8'h80);
    repeat (EEW) @(negedge core_clk);
    cmd_b(8'h05, 8'h00, 8'h00, RSP + 2, 3, scma_pkg::ACK_BYTE, 8'h12, 8'hC4);
    cmd_b(scma_pkg::CMD_REV, 8'h00, 8'h00, RSP + 2, 3, scma_pkg::ACK_BYTE, REV_B[15:8], REV_B[7:0]);
    cmd_b(8'hC3, 8'h00, 8'h00, 2, 1, 8'h82, 8'h00, 8'h00);
    cmd_b(scma_pkg::CMD_ADDR_WR, 8'h00, 8'hB3, EEW + 2, 1, scma_pkg::ACK_BYTE, 8'h00, 8'h00);
    wr_b(scma_pkg::CMD_LEAVE, 8'h00, 8'h00);
    repeat (RSP + 4) @(negedge core_clk);
    chk_bit(b_norm && !b_cmd, 1'b1);
    chk_byte({1'b0, b_addr}, 8'h33);
    tok_b(scma_pkg::TOK_START, scma_pkg::WR_FRAME_BYTE);
    idle_b;
    chk_bit(link_b.addr_ack, 1'b0);
    tok_b(scma_pkg::TOK_STOP, 8'h00);
    idle_b;
    rst_b = 1'b1;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b0;
    repeat (WIN + 5) @(negedge core_clk);
    chk_bit(b_norm && !b_cmd, 1'b1);
    wr_b(scma_pkg::CMD_ENTER, 8'h00, 8'h00);
    repeat (RSP + 4) @(negedge core_clk);
    chk_bit(b_cmd, 1'b0);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    rst_b = 1'b1;
    go = 1'b0;
    new_addr = 7'h31;
    link_b.tok_vld = 1'b0;
    link_b.tok_kind = scma_pkg::TOK_STOP;
    link_b.tok_data = 8'h00;
    link_b.rd_req = 1'b0;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    rst_b = 1'b0;
    fork
      flow_a;
      flow_b;
    join
    complete_run;
  end
endmodule
